// >>> rtl/dprc_pin_sync.sv
// Two-stage synchroniser for the fabric-side pin bundle
`timescale 1ns/10ps
module dprc_pin_sync
   import dprc_pkg::*;
#(
   parameter int WIDTH = DPRC_PIN_W
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // Pins in, synchronised copy out
   input wire logic [WIDTH-1:0] pins_i,
   output logic [WIDTH-1:0] pins_o
);
   typedef struct packed {
      logic [DPRC_SYNC_STAGES-1:0][WIDTH-1:0] stage;
   } dprc_sync_type;

   dprc_sync_type s_r;
   dprc_sync_type s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.stage[0] = pins_i;
      s_nxt.stage[1] = s_r.stage[0];
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Only the second stage leaves this module
   assign pins_o = s_r.stage[1];
endmodule : dprc_pin_sync

// >>> rtl/dprc_pkg.sv
// Constants and types shared by the dual-port RAM clocking wrapper
package dprc_pkg;
   // Array shape
   localparam int DPRC_WIDTH = 18;
   localparam int DPRC_LANE_W = 9;
   localparam int DPRC_LANES = 2;
   localparam int DPRC_AW = 4;
   localparam int DPRC_DEPTH = 16;
   // Pin bundle layout, per port: data, address, lane enables, write enable
   localparam int DPRC_PORT_W = DPRC_WIDTH + DPRC_AW + DPRC_LANES + 1;
   localparam int DPRC_OFS_ADDR = DPRC_WIDTH;
   localparam int DPRC_OFS_BE = DPRC_WIDTH + DPRC_AW;
   localparam int DPRC_OFS_WE = DPRC_WIDTH + DPRC_AW + DPRC_LANES;
   localparam int DPRC_OFS_CLK = 2 * DPRC_PORT_W;
   localparam int DPRC_OFS_CEN = DPRC_OFS_CLK + 2;
   localparam int DPRC_OFS_CLR = DPRC_OFS_CLK + 4;
   localparam int DPRC_PIN_W = DPRC_OFS_CLK + 6;
   localparam int DPRC_SYNC_STAGES = 2;
   // Register map, byte addresses
   localparam int DPRC_HADDR_W = 8;
   localparam logic [7:0] DPRC_REG_CTRL = 8'h00;
   localparam logic [7:0] DPRC_REG_STATUS = 8'h04;
   // Control register fields
   localparam int DPRC_CTRL_MODE = 0;
   localparam int DPRC_CTRL_SDP = 2;
   localparam int DPRC_CTRL_BYP_A = 3;
   localparam int DPRC_CTRL_BYP_B = 4;
   localparam int DPRC_CTRL_SPLIT = 5;
   localparam int DPRC_CTRL_WIDE = 6;
   localparam int DPRC_CTRL_W = 7;
   localparam logic [DPRC_CTRL_W-1:0] DPRC_CTRL_RESET = 7'h00;
   // Status register fields
   localparam int DPRC_STAT_LAST_A = 0;
   localparam int DPRC_STAT_LAST_B = 4;
   localparam int DPRC_STAT_CNT_A = 8;
   localparam int DPRC_STAT_CNT_B = 16;
   localparam int DPRC_CNT_W = 8;
   // AHB-Lite encodings
   localparam logic [1:0] DPRC_HTRANS_NONSEQ = 2'h2;
   localparam logic DPRC_HRESP_OKAY = 1'h0;
   // Clocking schemes
   typedef enum logic [1:0] {
      DPRC_MODE_IND = 2'b00,
      DPRC_MODE_IO = 2'b01,
      DPRC_MODE_RW = 2'b10,
      DPRC_MODE_SP = 2'b11
   } dprc_mode_type;
endpackage : dprc_pkg

// >>> rtl/dprc_top.sv
// Dual-port RAM with selectable clocking schemes and an AHB-Lite control slave
// Notes on behaviour
// - Independent mode: port A on clock A, B on B
// - Independent mode: per-port enable and clear
// - Input/output mode in true and simple dual-port
// - Input/output mode: input clock, separate output clock
// - Input/output mode: separate enables and clears per side
// - True dual-port input/output: every register clearable
// - Read/write mode: simple dual-port, two clocks
// - Write clock registers data, address, write strobe
// - Read clock registers address, strobe, output
// - Read/write mode: own enables, both sides clearable
// - Simple dual-port read strobe has no clear
// - Single-port mode with one shared port
// - Block splits into two small single-port memories
// - Each port: address, lanes, write enable, data
// - Writes touch only enabled byte lanes
// - Lane n gates nine bits at 9n
// - Port inputs clocked together, output register bypassable
//
// The register addresses and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/10ps
module dprc_top
   import dprc_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic [31:0] hrdata_o,
   // Shared clock control group
   input wire logic ram_clk_a_i,
   input wire logic ram_clk_b_i,
   input wire logic ram_cen_a_i,
   input wire logic ram_cen_b_i,
   input wire logic ram_clr_a_i,
   input wire logic ram_clr_b_i,
   // Port A
   input wire logic [DPRC_AW-1:0] addr_a_i,
   input wire logic [DPRC_LANES-1:0] be_a_i,
   input wire logic renwe_a_i,
   input wire logic [DPRC_WIDTH-1:0] din_a_i,
   output logic [DPRC_WIDTH-1:0] dout_a_o,
   // Port B
   input wire logic [DPRC_AW-1:0] addr_b_i,
   input wire logic [DPRC_LANES-1:0] be_b_i,
   input wire logic renwe_b_i,
   input wire logic [DPRC_WIDTH-1:0] din_b_i,
   output logic [DPRC_WIDTH-1:0] dout_b_o
);
   typedef struct packed {
      logic [DPRC_DEPTH-1:0][DPRC_WIDTH-1:0] mem;
      logic [1:0] clk_d;
      logic [1:0][DPRC_AW-1:0] addr;
      logic [1:0][DPRC_WIDTH-1:0] din;
      logic [1:0][DPRC_LANES-1:0] be;
      logic [1:0] we;
      logic [1:0][DPRC_WIDTH-1:0] rd;
      logic [1:0][DPRC_WIDTH-1:0] dout;
      logic [DPRC_CTRL_W-1:0] ctrl;
      logic [1:0][DPRC_CNT_W-1:0] wcnt;
      logic [1:0][DPRC_AW-1:0] lastw;
      logic wr_pend;
      logic [DPRC_HADDR_W-1:0] wr_addr;
      logic [31:0] rdata;
      logic readyout;
      logic resp;
   } dprc_state_type;

   dprc_state_type s_r;
   dprc_state_type s_nxt;
   logic [DPRC_PIN_W-1:0] sy;
   logic [1:0] sy_clk;
   logic [1:0] sy_cen;
   logic [1:0] sy_clr;
   logic [1:0] en;
   logic [1:0] ev_in;
   logic [1:0] ev_out;
   logic [1:0] clr_in;
   logic [1:0] clr_out;
   logic [1:0] wr_ok;
   logic [1:0] rd_ok;
   logic [1:0] bypass;
   logic sdp;
   logic split;
   logic wide;
   dprc_mode_type mode;

   // Lane merge of new data into an old word
   function automatic logic [DPRC_WIDTH-1:0] dprc_merge(
      input logic [DPRC_WIDTH-1:0] old,
      input logic [DPRC_WIDTH-1:0] data,
      input logic [DPRC_LANES-1:0] lanes
   );
      logic [DPRC_WIDTH-1:0] res;
      res = old;
      for (int l = 0; l < DPRC_LANES; l++) begin
         if (lanes[l]) begin
            res[l*DPRC_LANE_W +: DPRC_LANE_W] = data[l*DPRC_LANE_W +: DPRC_LANE_W];
         end
      end
      return res;
   endfunction : dprc_merge

   // Register decode, shared by the read and write paths
   function automatic logic dprc_hit(input logic [DPRC_HADDR_W-1:0] a,
                                     input logic [DPRC_HADDR_W-1:0] ofs);
      return a == ofs;
   endfunction : dprc_hit

   // Low half of a wide write comes from port A data
   function automatic logic [DPRC_WIDTH-1:0] din_lo(input logic [DPRC_WIDTH-1:0] d);
      return d;
   endfunction : din_lo

   // Fabric pins come from other clocks and pass two flops first
   dprc_pin_sync #(
      .WIDTH(DPRC_PIN_W)
   ) u_sync (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .pins_i({ram_clr_b_i, ram_clr_a_i, ram_cen_b_i, ram_cen_a_i, ram_clk_b_i, ram_clk_a_i,
               renwe_b_i, be_b_i, addr_b_i, din_b_i,
               renwe_a_i, be_a_i, addr_a_i, din_a_i}),
      .pins_o(sy)
   );

   assign sy_clk = sy[DPRC_OFS_CLK +: 2];
   assign sy_cen = sy[DPRC_OFS_CEN +: 2];
   assign sy_clr = sy[DPRC_OFS_CLR +: 2];
   assign en = sy_clk & ~s_r.clk_d & sy_cen;

   // Per-port fields of the synchronised pin bundle
   wire logic [1:0][DPRC_WIDTH-1:0] pin_din;
   wire logic [1:0][DPRC_AW-1:0] pin_addr;
   wire logic [1:0][DPRC_LANES-1:0] pin_be;
   wire logic [1:0] pin_we;
   for (genvar g = 0; g < 2; g++) begin : g_pin
      assign pin_din[g] = sy[g*DPRC_PORT_W +: DPRC_WIDTH];
      assign pin_addr[g] = sy[g*DPRC_PORT_W + DPRC_OFS_ADDR +: DPRC_AW];
      assign pin_be[g] = sy[g*DPRC_PORT_W + DPRC_OFS_BE +: DPRC_LANES];
      assign pin_we[g] = sy[g*DPRC_PORT_W + DPRC_OFS_WE];
   end

   // Map the two pin clocks onto the sides of each port
   always_comb begin
      mode = dprc_mode_type'(s_r.ctrl[DPRC_CTRL_MODE +: 2]);
      split = 1'b0;
      sdp = 1'b0;
      ev_in = 2'b00;
      ev_out = 2'b00;
      clr_in = 2'b00;
      clr_out = 2'b00;
      unique case (mode)
         DPRC_MODE_IND: begin
            ev_in = en;
            ev_out = en;
            clr_in = sy_clr;
            clr_out = sy_clr;
         end
         DPRC_MODE_IO: begin
            sdp = s_r.ctrl[DPRC_CTRL_SDP];
            ev_in = {en[0], en[0]};
            ev_out = {en[1], en[1]};
            clr_in = {sy_clr[0], sy_clr[0]};
            clr_out = {sy_clr[1], sy_clr[1]};
         end
         DPRC_MODE_RW: begin
            sdp = 1'b1;
            ev_in = en;
            ev_out = en;
            clr_in = sy_clr;
            clr_out = sy_clr;
         end
         DPRC_MODE_SP: begin
            split = s_r.ctrl[DPRC_CTRL_SPLIT];
            ev_in = {en[1] & split, en[0]};
            ev_out = {en[1] & split, en[0]};
            clr_in = sy_clr;
            clr_out = sy_clr;
         end
      endcase
      // Simple dual-port: A only writes, B only reads
      wr_ok = sdp ? 2'b01 : 2'b11;
      rd_ok = sdp ? 2'b10 : 2'b11;
      wide = sdp & s_r.ctrl[DPRC_CTRL_WIDE];
      bypass = {s_r.ctrl[DPRC_CTRL_BYP_B], s_r.ctrl[DPRC_CTRL_BYP_A]};
   end

   always_comb begin
      logic [DPRC_AW-1:0] pa;
      logic [DPRC_AW-1:0] wa;
      logic [DPRC_WIDTH-1:0] pd;
      logic [DPRC_LANES-1:0] pb;
      logic pw;
      logic [31:0] rv;
      pa = '0;
      wa = '0;
      pd = '0;
      pb = '0;
      pw = 1'b0;
      rv = '0;
      s_nxt = s_r;
      s_nxt.clk_d = sy_clk;
      // Port B first so that a same-address write from A lands last
      for (int p = 1; p >= 0; p--) begin
         pd = pin_din[p];
         pa = pin_addr[p];
         pb = pin_be[p];
         pw = pin_we[p];
         if (split) begin
            pa[DPRC_AW-1] = (p == 1);
         end
         if (ev_in[p]) begin
            // All inputs of a port are taken on the same edge
            s_nxt.addr[p] = pa;
            s_nxt.din[p] = pd;
            s_nxt.be[p] = pb;
            s_nxt.we[p] = pw;
            if (pw && wr_ok[p]) begin
               if (wide) begin
                  wa = {pa[DPRC_AW-1:1], 1'b0};
                  s_nxt.mem[wa] = dprc_merge(s_r.mem[wa], din_lo(pd), pb);
                  wa = {pa[DPRC_AW-1:1], 1'b1};
                  s_nxt.mem[wa] = dprc_merge(s_r.mem[wa], pin_din[1],
                                             pin_be[1]);
               end else begin
                  s_nxt.mem[pa] = dprc_merge(s_r.mem[pa], pd, pb);
               end
               s_nxt.wcnt[p] = s_r.wcnt[p] + 1'b1;
               s_nxt.lastw[p] = pa;
            end else if (!pw && rd_ok[p]) begin
               s_nxt.rd[p] = s_r.mem[pa];
               if (bypass[p]) begin
                  s_nxt.dout[p] = s_r.mem[pa];
               end
            end
         end
         if (ev_out[p] && !bypass[p]) begin
            s_nxt.dout[p] = s_r.rd[p];
         end
         // Clears beat clock and enable but never touch the array
         if (clr_in[p]) begin
            s_nxt.addr[p] = '0;
            s_nxt.din[p] = '0;
            s_nxt.be[p] = '0;
            s_nxt.rd[p] = '0;
            if (!(sdp && p == 1)) begin
               s_nxt.we[p] = 1'b0;
            end
         end
         if (clr_out[p]) begin
            s_nxt.dout[p] = '0;
         end
      end
      // Bus slave, zero wait states
      s_nxt.readyout = 1'b1;
      s_nxt.resp = DPRC_HRESP_OKAY;
      s_nxt.wr_pend = 1'b0;
      if (s_r.wr_pend && dprc_hit(s_r.wr_addr, DPRC_REG_CTRL)) begin
         s_nxt.ctrl = hwdata_i[DPRC_CTRL_W-1:0];
      end
      if (hsel_i && hready_i && htrans_i == DPRC_HTRANS_NONSEQ) begin
         if (hwrite_i) begin
            s_nxt.wr_pend = 1'b1;
            s_nxt.wr_addr = haddr_i[DPRC_HADDR_W-1:0];
         end else begin
            if (dprc_hit(haddr_i[DPRC_HADDR_W-1:0], DPRC_REG_CTRL)) begin
               rv[DPRC_CTRL_W-1:0] = s_r.ctrl;
            end else if (dprc_hit(haddr_i[DPRC_HADDR_W-1:0], DPRC_REG_STATUS)) begin
               rv[DPRC_STAT_LAST_A +: DPRC_AW] = s_r.lastw[0];
               rv[DPRC_STAT_LAST_B +: DPRC_AW] = s_r.lastw[1];
               rv[DPRC_STAT_CNT_A +: DPRC_CNT_W] = s_r.wcnt[0];
               rv[DPRC_STAT_CNT_B +: DPRC_CNT_W] = s_r.wcnt[1];
            end
            s_nxt.rdata = rv;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign hreadyout_o = s_r.readyout;
   assign hresp_o = s_r.resp;
   assign hrdata_o = s_r.rdata;
   assign dout_a_o = s_r.dout[0];
   assign dout_b_o = s_r.dout[1];
endmodule : dprc_top

// >>> sim/dprc_fabric_model.sv
// Fabric-side clock source for the two RAM ports
`timescale 1ns/10ps
module dprc_fabric_model (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // One request per port starts one RAM clock period
   input wire logic [1:0] pulse_i,
   // RAM clocks, still between requests
   output logic [1:0] ram_clk_o
);
   for (genvar p = 0; p < 2; p++) begin : g_port
      logic [3:0] cnt_r;
      always_ff @(posedge clk_sys_i) begin
         if (!resetn_i) begin
            cnt_r <= 4'h0;
         end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
         end else if (pulse_i[p]) begin
            cnt_r <= 4'h8;
         end
      end
      // Four high, four low: four times the one cycle per level the pin sampler needs, so no edge is lost
      assign ram_clk_o[p] = cnt_r > 4'h4;
   end
endmodule : dprc_fabric_model

// >>> sim/dprc_top_monitor.sv
// Assertion checker for the dual-port RAM clocking wrapper
`timescale 1ns/10ps
module dprc_top_monitor
   import dprc_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // Bus
   input wire logic hsel_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic hready_i,
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   input wire logic [31:0] hrdata_o,
   // RAM control group and read data
   input wire logic ram_clk_a_i,
   input wire logic ram_clk_b_i,
   input wire logic ram_cen_a_i,
   input wire logic ram_cen_b_i,
   input wire logic ram_clr_a_i,
   input wire logic ram_clr_b_i,
   input wire logic [DPRC_WIDTH-1:0] dout_a_o,
   input wire logic [DPRC_WIDTH-1:0] dout_b_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);
   logic rd_req;
   logic [3:0] idle_r;
   assign rd_req = hsel_i && hready_i && htrans_i == DPRC_HTRANS_NONSEQ && !hwrite_i;
   // Cycles since a RAM clock rose or a clear was seen; pin sync adds two cycles
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i || $rose(ram_clk_a_i) || $rose(ram_clk_b_i) ||
          ram_clr_a_i || ram_clr_b_i) begin
         idle_r <= 4'h0;
      end else if (idle_r != 4'hf) begin
         idle_r <= idle_r + 4'h1;
      end
   end
   sequence s_clr_both;
      ram_clr_a_i && ram_clr_b_i;
   endsequence
   sequence s_cen_off;
      !ram_cen_a_i && !ram_cen_b_i && !ram_clr_a_i && !ram_clr_b_i;
   endsequence
   a_resp_always_okay: assert property (hresp_o == DPRC_HRESP_OKAY)
      else $error("hresp not OKAY");
   a_ready_after_reset: assert property ($rose(resetn_i) |=> hreadyout_o [*2])
      else $error("hreadyout low after reset");
   a_ready_zero_wait: assert property ($past(resetn_i) |-> hreadyout_o)
      else $error("wait state inserted");
   a_rdata_stands: assert property ($changed(hrdata_o) |-> $past(rd_req))
      else $error("hrdata moved without a read");
   a_dout_a_quiet: assert property ($changed(dout_a_o) |-> idle_r < 4'h6)
      else $error("dout_a moved without clock or clear");
   a_dout_b_quiet: assert property ($changed(dout_b_o) |-> idle_r < 4'h6)
      else $error("dout_b moved without clock or clear");
   a_clr_zeroes_out: assert property (s_clr_both [*6] |->
      dout_a_o == '0 && dout_b_o == '0)
      else $error("clear did not zero outputs");
   a_cen_off_hold: assert property (s_cen_off [*8] |->
      $stable(dout_a_o) && $stable(dout_b_o))
      else $error("outputs moved with enables low");
endmodule : dprc_top_monitor

bind dprc_top dprc_top_monitor u_mon (.clk_sys_i, .resetn_i, .hsel_i, .htrans_i, .hwrite_i,
   .hready_i, .hreadyout_o, .hresp_o, .hrdata_o, .ram_clk_a_i, .ram_clk_b_i, .ram_cen_a_i,
   .ram_cen_b_i, .ram_clr_a_i, .ram_clr_b_i, .dout_a_o, .dout_b_o);

// >>> sim/dprc_top_tb.sv
// Self-checking bench for the dual-port RAM clocking wrapper
`timescale 1ns/10ps
module dprc_top_tb
   import dprc_pkg::*;
;
   logic clk_sys_i = 1'b0;
   logic resetn_i = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic [1:0] clk_ram;
   logic [1:0] pulse = 2'h0;
   logic [1:0] cen = 2'h3;
   logic [1:0] clr = 2'h0;
   logic [1:0] we = 2'h0;
   logic [1:0][3:0] addr = '0;
   logic [1:0][1:0] be = '1;
   logic [1:0][DPRC_WIDTH-1:0] din = '0;
   logic [1:0][DPRC_WIDTH-1:0] dout;
   logic [DPRC_WIDTH-1:0] mem_m [16] = '{default: '0};
   int error_cnt = 0;
   int total_checks = 0;
   int cyc = 0;
   integer seed = 32'h1083f3ac;

   dprc_top u_dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
      .hready_i(hreadyout), .hreadyout_o(hreadyout), .hresp_o(hresp), .hrdata_o(hrdata),
      .ram_clk_a_i(clk_ram[0]), .ram_clk_b_i(clk_ram[1]), .ram_cen_a_i(cen[0]),
      .ram_cen_b_i(cen[1]), .ram_clr_a_i(clr[0]), .ram_clr_b_i(clr[1]),
      .addr_a_i(addr[0]), .be_a_i(be[0]), .renwe_a_i(we[0]), .din_a_i(din[0]),
      .dout_a_o(dout[0]), .addr_b_i(addr[1]), .be_b_i(be[1]), .renwe_b_i(we[1]),
      .din_b_i(din[1]), .dout_b_o(dout[1]));
   dprc_fabric_model u_fab (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .pulse_i(pulse),
      .ram_clk_o(clk_ram));

   always #5 clk_sys_i = ~clk_sys_i;

   task automatic give_verdict();
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : give_verdict

   // About fifty RAM periods of eleven cycles; the ceiling leaves ample room
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         give_verdict();
      end
   end

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= DPRC_HTRANS_NONSEQ;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge clk_sys_i); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_sys_i); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask : ahb

   // Pins stay put for the whole RAM period, so the sampler never sees them move
   task automatic op(input int p, input logic w, input logic [3:0] a, input logic [1:0] b,
                     input logic [DPRC_WIDTH-1:0] d);
      we[p] <= w;
      addr[p] <= a;
      be[p] <= b;
      din[p] <= d;
      pulse[p] <= 1'b1;
      @(posedge clk_sys_i);
      pulse[p] <= 1'b0;
      repeat (10) @(posedge clk_sys_i);
   endtask : op

   task automatic rdp(input int p, input logic [3:0] a);
      repeat (2) op(p, 1'b0, a, 2'h3, '0);
   endtask : rdp

   function automatic logic [DPRC_WIDTH-1:0] merge(input logic [DPRC_WIDTH-1:0] o,
      input logic [DPRC_WIDTH-1:0] d, input logic [1:0] b);
      merge = {b[1] ? d[17:9] : o[17:9], b[0] ? d[8:0] : o[8:0]};
   endfunction : merge

   initial begin
      int p;
      logic [3:0] a;
      logic [1:0] b;
      logic [DPRC_WIDTH-1:0] d;
      logic [DPRC_WIDTH-1:0] ea;
      logic [1:0][7:0] nw;
      logic [1:0][3:0] la;
      logic [31:0] rd;
      nw = '0;
      la = '0;
      repeat (6) @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      ahb(1'b0, DPRC_REG_CTRL, 32'h0, rd);
      check("ctrl_reset", rd, 32'h0);
      // Independent clocks: write on one port, read back through the other
      for (int i = 0; i < 8; i++) begin
         p = i % 2;
         a = 4'($random(seed));
         d = DPRC_WIDTH'($random(seed));
         b = (i < 2) ? 2'(i + 1) : 2'h3;
         op(p, 1'b1, a, b, d);
         mem_m[a] = merge(mem_m[a], d, b);
         nw[p]++;
         la[p] = a;
         rdp(1 - p, a);
         ea = mem_m[a];
         check("dout_cross", dout[1-p], mem_m[a]);
      end
      cen <= 2'h0;
      op(0, 1'b1, la[0], 2'h3, ~mem_m[la[0]]);
      cen <= 2'h3;
      rdp(1, la[0]);
      check("cen_low", dout[1], mem_m[la[0]]);
      ahb(1'b0, DPRC_REG_STATUS, 32'h0, rd);
      check("status", rd, {8'h0, nw[1], nw[0], la[1], la[0]});
      ahb(1'b1, 8'h08, 32'hffffffff, rd);
      ahb(1'b0, 8'h08, 32'h0, rd);
      check("unmapped", rd, 32'h0);
      // Clear port B first: port A must keep its output
      clr <= 2'h2;
      repeat (6) @(posedge clk_sys_i);
      check("clr_b", dout[1], 32'h0);
      check("keep_a", dout[0], ea);
      clr <= 2'h3;
      repeat (8) @(posedge clk_sys_i);
      check("clr_a", dout[0], 32'h0);
      clr <= 2'h0;
      a = la[0];
      rdp(0, a);
      check("mem_kept", dout[0], mem_m[a]);
      // Input/output mode: clock A captures, clock B drives the outputs
      ahb(1'b1, DPRC_REG_CTRL, 32'h1, rd);
      ea = mem_m[a];
      d = DPRC_WIDTH'($random(seed));
      op(0, 1'b1, a, 2'h3, d);
      mem_m[a] = d;
      op(0, 1'b0, a, 2'h3, '0);
      check("io_hold", dout[0], ea);
      op(1, 1'b0, a, 2'h3, '0);
      check("io_out", dout[0], mem_m[a]);
      // Read/write mode: port B writes are refused, A writes, B reads
      ahb(1'b1, DPRC_REG_CTRL, 32'h2, rd);
      op(1, 1'b1, a, 2'h3, ~d);
      d = DPRC_WIDTH'($random(seed));
      op(0, 1'b1, a, 2'h1, d);
      mem_m[a] = merge(mem_m[a], d, 2'h1);
      rdp(1, a);
      check("rw_read", dout[1], mem_m[a]);
      // Single port with the output register bypassed: one period per read
      ahb(1'b1, DPRC_REG_CTRL, 32'hb, rd);
      ahb(1'b0, DPRC_REG_CTRL, 32'h0, rd);
      check("ctrl_rb", rd, 32'hb);
      d = DPRC_WIDTH'($random(seed));
      op(0, 1'b1, a, 2'h3, d);
      mem_m[a] = d;
      op(0, 1'b0, a, 2'h3, '0);
      check("sp_bypass", dout[0], mem_m[a]);
      // Split single port: A lands in the low half, B in the high half
      ahb(1'b1, DPRC_REG_CTRL, 32'h23, rd);
      d = DPRC_WIDTH'($random(seed));
      op(0, 1'b1, 4'h9, 2'h3, d);
      op(1, 1'b1, 4'h1, 2'h3, ~d);
      mem_m[1] = d;
      mem_m[9] = ~d;
      rdp(0, 4'h1);
      check("split_a", dout[0], mem_m[1]);
      rdp(1, 4'h9);
      check("split_b", dout[1], mem_m[9]);
      // Wide write: port A strobes both words, port B output bypassed
      ahb(1'b1, DPRC_REG_CTRL, 32'h52, rd);
      d = DPRC_WIDTH'($random(seed));
      ea = DPRC_WIDTH'($random(seed));
      din[1] <= ea;
      be[1] <= 2'h2;
      @(posedge clk_sys_i);
      op(0, 1'b1, 4'h4, 2'h1, d);
      mem_m[4] = merge(mem_m[4], d, 2'h1);
      mem_m[5] = merge(mem_m[5], ea, 2'h2);
      for (int w = 4; w < 6; w++) begin
         op(1, 1'b0, 4'(w), 2'h3, '0);
         check("wide_byp", dout[1], mem_m[w]);
      end
      // Input/output mode, simple dual-port: output clear keeps the read latch
      ahb(1'b1, DPRC_REG_CTRL, 32'h5, rd);
      op(1, 1'b0, 4'h4, 2'h3, '0);
      op(0, 1'b0, 4'h4, 2'h3, '0);
      clr <= 2'h2;
      repeat (4) @(posedge clk_sys_i);
      check("io_clr_out", dout[1], 32'h0);
      clr <= 2'h0;
      op(1, 1'b0, 4'h4, 2'h3, '0);
      check("io_sdp_read", dout[1], mem_m[4]);
      give_verdict();
   end
endmodule : dprc_top_tb
